// File: hdl/parity_unit.v
// Purpose: Parity bit generation for transmit and checking for receive.
// Assumes: Data below the programmed length sits in the low bits.
// Notes: Pure combinational logic.
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_consts.vh"

module parity_unit (
  input wire [1:0] char_bits,
  input wire [1:0] parity_mode,
  input wire parity_type,
  input wire [7:0] tx_data,
  input wire [7:0] rx_data,
  input wire rx_parity_bit,
  output reg tx_parity_bit,
  output reg tx_parity_used,
  output reg rx_parity_error
);

  reg [7:0] mask;
  reg tx_ones;
  reg rx_ones;

  always @* begin
    case (char_bits)
      `BITS_FIVE: mask = 8'h1F;
      `BITS_SIX: mask = 8'h3F;
      `BITS_SEVEN: mask = 8'h7F;
      default: mask = 8'hFF;
    endcase
    tx_ones = ^(tx_data & mask);
    rx_ones = ^(rx_data & mask);
    tx_parity_bit = 1'b0;
    tx_parity_used = 1'b0;
    rx_parity_error = 1'b0;
    case (parity_mode)
      `PAR_WITH: begin
        tx_parity_used = 1'b1;
        tx_parity_bit = tx_ones ^ parity_type;
        rx_parity_error = rx_ones ^ parity_type ^ rx_parity_bit;
      end
      `PAR_FORCE: begin
        tx_parity_used = 1'b1;
        tx_parity_bit = parity_type;
        rx_parity_error = rx_parity_bit ^ parity_type;
      end
      `PAR_MULTIDROP: begin
        tx_parity_used = 1'b1;
        tx_parity_bit = parity_type;
      end
      default: begin
        tx_parity_used = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// File: hdl/rx_status_fifo.v
// Purpose: Receive FIFO that carries per-character status with the data.
// Assumes: Push and pop are single-cycle strobes on the same clock.
// Notes: A push while full is dropped; the caller counts it as overrun.
`timescale 1ns/100ps
`default_nettype none

module rx_status_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire pclk,
  input wire presetn,
  input wire clear,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output wire [WIDTH-1:0] head,
  output wire empty,
  output wire full
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] rd_ptr;
  reg [AW-1:0] wr_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;
  integer i;

  assign empty = (count == {(AW+1){1'b0}});
  assign full = (count == DEPTH[AW:0]);
  assign head = mem[rd_ptr];
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else if (clear) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        mem[wr_ptr] <= push_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop & ~do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// File: hdl/uart_mode_consts.vh
// Purpose: Constants for the serial channel mode, status and interrupt logic.
// Assumes: APB byte addresses, one 32-bit aligned word per register.
// Notes: Data bits above bit 7 read as zero.
//
// Summary of operation
// - Pointer resets to mode one, advances after access.
// - Request-to-send follows output port bit zero.
// - Flow control negates request-to-send on start while full.
// - Auto negation keeps port bit; reasserts when space.
// - Mode bit 6 picks receiver interrupt source.
// - Chosen receiver status drives pin four if configured.
// - Error mode governs framing, parity, break only.
// - Character mode reports head character flags only.
// - Block mode ORs flags since last error reset.
// - With or forced parity: append and check parity.
// - Parity field 11 selects multidrop mode.
// - Parity type picks odd/even or forced value.
// - Parity type ignored without parity.
// - Multidrop: parity type sets address/data bit.
// - Aux control bit 7 selects baud rate set.
// - Interrupt mask holds eight per-condition enables.
// - Counter upper register holds preset bits 15..8.
// - Interrupt select 0 ready, 1 fifo full.
// - Error mode 0 character, 1 block.
// - Parity field: 00 with, 01 force, 10 none, 11 multidrop.
// - Block flags cleared by error or receiver reset.
`ifndef UART_MODE_CONSTS_VH
`define UART_MODE_CONSTS_VH

// ********************************************************
// Register byte addresses
// ********************************************************
`define ADDR_MODE 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_COMMAND 8'h08
`define ADDR_RX_DATA 8'h0C
`define ADDR_AUX_CONTROL 8'h10
`define ADDR_INPUT_CHANGE 8'h14
`define ADDR_INT_STATUS 8'h18
`define ADDR_INT_MASK 8'h1C
`define ADDR_COUNTER_HIGH 8'h20
`define ADDR_PIN_CONFIG 8'h24
`define ADDR_OUTPUT_BITS 8'h28

// ********************************************************
// Field positions
// ********************************************************
`define MODE1_RTS_CTRL 7
`define MODE1_INT_SEL 6
`define MODE1_ERR_MODE 5
`define MODE1_PAR_HI 4
`define MODE1_PAR_LO 3
`define MODE1_PAR_TYPE 2
`define AUX_BRG_SET 7
`define PIN_CONFIG_OP4 4
`define CMD_HI 6
`define CMD_LO 4

// ********************************************************
// Codes and reset values
// ********************************************************
`define PAR_WITH 2'h0
`define PAR_FORCE 2'h1
`define PAR_NONE 2'h2
`define PAR_MULTIDROP 2'h3
`define CMD_SET_POINTER 3'h1
`define CMD_RX_RESET 3'h2
`define CMD_ERR_RESET 3'h4
`define REG_RESET 8'h00
`define BITS_FIVE 2'h0
`define BITS_SIX 2'h1
`define BITS_SEVEN 2'h2

`endif

// File: hdl/uart_mode_one_and_interrupt_regs.v
// Purpose: Mode, status, flow control and interrupt registers of a channel.
// Assumes: Receiver and transmitter logic run on pclk; input port pins
//   are asynchronous.
// Notes: APB slave, pready answers in the first access cycle.
`timescale 1ns/100ps
`default_nettype none
`include "uart_mode_consts.vh"

module uart_mode_one_and_interrupt_regs #(
  parameter FIFO_DEPTH = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_start_bit,
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  input wire rx_char_parity_bit,
  input wire rx_char_framing,
  input wire rx_char_break,
  input wire [7:0] tx_char_data,
  input wire transmit_ready,
  input wire transmit_empty,
  input wire [3:0] input_pins,
  input wire break_change_a,
  input wire break_change_b,
  input wire receiver_b_int,
  input wire transmit_ready_b,
  input wire counter_ready,
  output reg receiver_rts_out_n,
  output reg output_pin_four,
  output reg tx_parity_bit,
  output reg tx_parity_used,
  output reg brg_set_two,
  output reg [7:0] counter_high,
  output reg [7:0] mode_two_bits,
  output reg irq_n
);

  // ********************************************************
  // Registers
  // ********************************************************
  reg [7:0] channel_mode_one;
  reg [7:0] channel_mode_two;
  reg mode_pointer;
  reg [7:0] aux_control;
  reg [7:0] interrupt_mask;
  reg [7:0] counter_preset_high;
  reg [7:0] output_pin_config;
  reg [7:0] output_port_bits;
  reg rts_auto_negated;
  reg [2:0] block_flags;
  reg overrun;
  reg [3:0] pin_meta;
  reg [3:0] pin_sync;
  reg [3:0] pin_prev;
  reg [3:0] pin_delta;
  reg [3:0] delta_seen;

  // ********************************************************
  // Bus decode
  // ********************************************************
  wire setup_phase;
  wire access_done;
  wire wr_done;
  wire rd_done;
  wire [2:0] command;
  wire cmd_write;
  wire rx_reset;
  wire err_reset;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done = access_done & pwrite & ~pslverr;
  assign rd_done = access_done & ~pwrite & ~pslverr;
  assign command = pwdata[`CMD_HI:`CMD_LO];
  assign cmd_write = wr_done & (paddr == `ADDR_COMMAND);
  assign rx_reset = cmd_write & (command == `CMD_RX_RESET);
  assign err_reset = cmd_write & (command == `CMD_ERR_RESET);

  function addr_mapped;
    input [7:0] a;
    input w;
    begin
      case (a)
        `ADDR_MODE, `ADDR_INT_MASK, `ADDR_AUX_CONTROL,
        `ADDR_COUNTER_HIGH, `ADDR_PIN_CONFIG,
        `ADDR_OUTPUT_BITS: addr_mapped = 1'b1;
        `ADDR_COMMAND: addr_mapped = w;
        `ADDR_STATUS, `ADDR_RX_DATA, `ADDR_INPUT_CHANGE,
        `ADDR_INT_STATUS: addr_mapped = ~w;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction

  // ********************************************************
  // Receive FIFO and parity
  // ********************************************************
  wire [10:0] fifo_head;
  wire fifo_empty;
  wire fifo_full;
  wire rx_parity_error;
  wire next_tx_parity_bit;
  wire next_tx_parity_used;
  wire fifo_pop;

  assign fifo_pop = rd_done & (paddr == `ADDR_RX_DATA);

  parity_unit u_parity (
    .char_bits(channel_mode_one[1:0]),
    .parity_mode(channel_mode_one[`MODE1_PAR_HI:`MODE1_PAR_LO]),
    .parity_type(channel_mode_one[`MODE1_PAR_TYPE]),
    .tx_data(tx_char_data),
    .rx_data(rx_char_data),
    .rx_parity_bit(rx_char_parity_bit),
    .tx_parity_bit(next_tx_parity_bit),
    .tx_parity_used(next_tx_parity_used),
    .rx_parity_error(rx_parity_error)
  );

  // Head layout: break, framing, parity, then the data byte.
  rx_status_fifo #(
    .WIDTH(11),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .clear(rx_reset),
    .push(rx_char_valid),
    .push_data({rx_char_break, rx_char_framing, rx_parity_error,
                rx_char_data}),
    .pop(fifo_pop),
    .head(fifo_head),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // ********************************************************
  // Status composition
  // ********************************************************
  wire rx_ready;
  wire rx_int_source;
  wire [2:0] head_flags;
  wire [2:0] shown_flags;
  wire [7:0] channel_status;
  wire [7:0] input_change_status;
  wire [7:0] interrupt_status;
  wire port_change;

  assign rx_ready = ~fifo_empty;
  assign rx_int_source = channel_mode_one[`MODE1_INT_SEL] ?
                         fifo_full : rx_ready;
  assign head_flags = fifo_empty ? 3'h0 : fifo_head[10:8];
  // Block mode shows the accumulation, character mode the head only.
  assign shown_flags = channel_mode_one[`MODE1_ERR_MODE] ?
                       block_flags : head_flags;
  assign channel_status = {shown_flags, overrun, transmit_empty,
                           transmit_ready, fifo_full, rx_ready};
  assign input_change_status = {pin_delta, pin_sync};
  assign port_change = |(pin_delta & aux_control[3:0]);
  assign interrupt_status = {port_change, break_change_b, receiver_b_int,
                             transmit_ready_b, counter_ready,
                             break_change_a, rx_int_source,
                             transmit_ready};

  // ********************************************************
  // APB slave
  // ********************************************************
  reg [7:0] next_read;

  always @* begin
    case (paddr)
      `ADDR_MODE: next_read = mode_pointer ? channel_mode_two :
                              channel_mode_one;
      `ADDR_STATUS: next_read = channel_status;
      `ADDR_RX_DATA: next_read = fifo_empty ? 8'h00 : fifo_head[7:0];
      `ADDR_INPUT_CHANGE: next_read = input_change_status;
      `ADDR_INT_STATUS: next_read = interrupt_status;
      `ADDR_PIN_CONFIG: next_read = output_pin_config;
      `ADDR_OUTPUT_BITS: next_read = output_port_bits;
      default: next_read = 8'h00;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      delta_seen <= 4'h0;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= ~addr_mapped(paddr, pwrite);
      prdata <= (pwrite | ~addr_mapped(paddr, pwrite)) ? 32'h00000000 :
                {24'h000000, next_read};
      delta_seen <= (~pwrite & (paddr == `ADDR_INPUT_CHANGE)) ?
                    pin_delta : 4'h0;
    end else if (access_done) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ********************************************************
  // Software registers
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_mode_one <= `REG_RESET;
      channel_mode_two <= `REG_RESET;
      mode_pointer <= 1'b0;
      aux_control <= `REG_RESET;
      interrupt_mask <= `REG_RESET;
      counter_preset_high <= `REG_RESET;
      output_pin_config <= `REG_RESET;
      output_port_bits <= `REG_RESET;
    end else begin
      if (cmd_write & (command == `CMD_SET_POINTER)) begin
        mode_pointer <= 1'b0;
      end else if (access_done & ~pslverr & (paddr == `ADDR_MODE)) begin
        if (!mode_pointer) begin
          mode_pointer <= 1'b1;
          if (pwrite) begin
            channel_mode_one <= pwdata[7:0];
          end
        end else if (pwrite) begin
          channel_mode_two <= pwdata[7:0];
        end
      end
      if (wr_done) begin
        case (paddr)
          `ADDR_AUX_CONTROL: aux_control <= pwdata[7:0];
          `ADDR_INT_MASK: interrupt_mask <= pwdata[7:0];
          `ADDR_COUNTER_HIGH: counter_preset_high <= pwdata[7:0];
          `ADDR_PIN_CONFIG: output_pin_config <= pwdata[7:0];
          `ADDR_OUTPUT_BITS: output_port_bits <= pwdata[7:0];
          default: output_port_bits <= output_port_bits;
        endcase
      end
    end
  end

  // ********************************************************
  // Receiver flow control and error accumulation
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_auto_negated <= 1'b0;
      block_flags <= 3'h0;
      overrun <= 1'b0;
    end else begin
      // Negation leaves the port bit alone and lifts once space exists.
      if (channel_mode_one[`MODE1_RTS_CTRL] & rx_start_bit & fifo_full) begin
        rts_auto_negated <= 1'b1;
      end else if (!fifo_full) begin
        rts_auto_negated <= 1'b0;
      end
      // Each head character is folded in; a new event beats an error reset, not a receiver reset.
      if (rx_reset | err_reset) begin
        block_flags <= head_flags & {3{~rx_reset}};
      end else begin
        block_flags <= block_flags | head_flags;
      end
      if (rx_char_valid & fifo_full & ~rx_reset) begin
        overrun <= 1'b1;
      end else if (rx_reset | err_reset) begin
        overrun <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Input port change detection
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      pin_prev <= 4'h0;
      pin_delta <= 4'h0;
    end else begin
      pin_meta <= input_pins;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      // Only deltas returned by the read are cleared; a new one wins.
      pin_delta <= (pin_delta & ~(delta_seen & {4{rd_done}})) |
                   (pin_sync ^ pin_prev);
    end
  end

  // ********************************************************
  // Output flops
  // ********************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receiver_rts_out_n <= 1'b1;
      output_pin_four <= 1'b1;
      tx_parity_bit <= 1'b0;
      tx_parity_used <= 1'b0;
      brg_set_two <= 1'b0;
      counter_high <= `REG_RESET;
      mode_two_bits <= `REG_RESET;
      irq_n <= 1'b1;
    end else begin
      // The pin level is the inverse of the port bit unless auto negation or the pin four receiver status selection overrides it.
      receiver_rts_out_n <= ~(output_port_bits[0] &
                              ~rts_auto_negated);
      output_pin_four <= output_pin_config[`PIN_CONFIG_OP4] ?
                         ~rx_int_source : ~output_port_bits[4];
      tx_parity_bit <= next_tx_parity_bit;
      tx_parity_used <= next_tx_parity_used;
      brg_set_two <= aux_control[`AUX_BRG_SET];
      counter_high <= counter_preset_high;
      mode_two_bits <= channel_mode_two;
      irq_n <= ~|(interrupt_status & interrupt_mask);
    end
  end

endmodule
`default_nettype wire

// File: sim/remote_sender.sv
// Purpose: Remote serial transmitter as seen after bit recovery.
// Assumes: A start pulse, then one character pulse, both on pclk.
// Notes: Released character lines show the inverse of the last value.
`timescale 1ns/100ps
`default_nettype none
module remote_sender (
  input wire logic pclk,
  output logic start_bit,
  output logic char_valid,
  output logic [7:0] char_data,
  output logic parity_bit,
  output logic framing,
  output logic brk_flag
);
  initial begin
    start_bit = 1'b0;
    char_valid = 1'b0;
    char_data = 8'h00;
    parity_bit = 1'b0;
    framing = 1'b0;
    brk_flag = 1'b0;
  end
  // It sends whatever it is told, even into a full receiver.
  task automatic send(input logic [7:0] d, input logic p, input logic f,
                      input logic b);
    @(posedge pclk);
    start_bit <= 1'b1;
    @(posedge pclk);
    start_bit <= 1'b0;
    char_valid <= 1'b1;
    char_data <= d;
    parity_bit <= p;
    framing <= f;
    brk_flag <= b;
    @(posedge pclk);
    char_valid <= 1'b0;
    char_data <= ~d;
    parity_bit <= ~p;
    framing <= ~f;
    brk_flag <= ~b;
  endtask
endmodule
`default_nettype wire

// File: sim/uart_mode_one_and_interrupt_regs_bench.sv
// Purpose: Self-checking bench for the mode, status and interrupt block.
// Assumes: Zero wait-state APB slave; four-deep receive queue.
// Notes: Bus responses are checked from a queue of expected values.
`timescale 1ns/100ps
`default_nettype none
module uart_mode_one_and_interrupt_regs_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, tx_char_data, fill0, d, mode_two_bits, counter_high;
  logic [31:0] pwdata, prdata, seed;
  logic [32:0] exp_resp;
  logic [6:0] cond;
  logic [3:0] pins;
  logic rts_n, pin_four, par_bit, par_used, brg_two, irq_n;
  logic s_start, s_valid, s_par, s_fe, s_brk;
  logic [7:0] s_data;
  logic [32:0] q[$];
  int num_errors, tests_run, cycles;
  uart_mode_one_and_interrupt_regs #(.FIFO_DEPTH(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_start_bit(s_start),
    .rx_char_valid(s_valid), .rx_char_data(s_data),
    .rx_char_parity_bit(s_par), .rx_char_framing(s_fe),
    .rx_char_break(s_brk), .tx_char_data(tx_char_data),
    .transmit_ready(cond[0]), .transmit_empty(1'b0),
    .input_pins(pins), .break_change_a(cond[2]),
    .break_change_b(cond[6]), .receiver_b_int(cond[5]),
    .transmit_ready_b(cond[4]), .counter_ready(cond[3]),
    .receiver_rts_out_n(rts_n), .output_pin_four(pin_four),
    .tx_parity_bit(par_bit), .tx_parity_used(par_used),
    .brg_set_two(brg_two), .counter_high(counter_high),
    .mode_two_bits(mode_two_bits), .irq_n(irq_n));
  remote_sender u_far (.pclk(pclk), .start_bit(s_start),
    .char_valid(s_valid), .char_data(s_data), .parity_bit(s_par),
    .framing(s_fe), .brk_flag(s_brk));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic check(input string name, input logic [7:0] e,
                       input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, input logic [32:0] e);
    q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h000000000);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h00000000, {25'h0000000, e});
  endtask
  task automatic set_mode1(input logic [7:0] v);
    wr(8'h08, 32'h00000010);
    wr(8'h00, {24'h000000, v});
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Every bus response is compared with the oldest expectation.
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      exp_resp = (q.size() > 0) ? q.pop_front() : 33'h1FFFFFFFF;
      tests_run++;
      if ({pslverr, prdata} !== exp_resp) begin
        num_errors++;
        $display("FAIL bus %h expected %h seen %h", paddr, exp_resp,
                 {pslverr, prdata});
      end
    end
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("FAIL timeout expected done seen running");
      results();
    end
  end
  initial begin
    seed = 32'h00000035;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    tx_char_data = 8'h00;
    cond = 7'h00;
    pins = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ticks(3);
    check("rts_n", 8'h01, {7'h00, rts_n});
    check("irq_n", 8'h01, {7'h00, irq_n});
    check("pin_four", 8'h01, {7'h00, pin_four});
    set_mode1(8'h03);
    wr(8'h00, 32'h000000A5);
    ticks(1);
    check("mode_two", 8'hA5, mode_two_bits);
    wr(8'h08, 32'h00000010);
    rd(8'h00, 8'h03);
    rd(8'h00, 8'hA5);
    rd(8'h00, 8'hA5);
    apb(1'b0, 8'h2C, 32'h00000000, 33'h100000000);
    apb(1'b1, 8'h04, 32'h000000FF, 33'h100000000);
    rd(8'h10, 8'h00);
    $display("Test pointer and refusals done");
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      wr(8'h10, {24'h000000, d});
      wr(8'h20, {24'h000000, ~d});
      ticks(1);
      check("brg_set_two", {7'h00, d[7]}, {7'h00, brg_two});
      check("counter_high", ~d, counter_high);
    end
    for (int m = 0; m < 8; m++) begin
      set_mode1({3'h0, m[2:0], 2'h3});
      d = rnd();
      @(posedge pclk);
      tx_char_data <= d;
      ticks(2);
      check("par_used", {7'h00, m[2:1] != 2'h2}, {7'h00, par_used});
      if (m[2:1] != 2'h2)
        check("par_bit", {7'h00, m[2:1] == 2'h0 ? ^d ^ m[0] : m[0]},
              {7'h00, par_bit});
    end
    $display("Test parity modes done");
    wr(8'h08, 32'h00000020);
    set_mode1(8'h03);
    u_far.send(8'h5A, 1'b1, 1'b1, 1'b0);
    u_far.send(8'h3C, 1'b0, 1'b0, 1'b0);
    rd(8'h04, 8'h61);
    rd(8'h0C, 8'h5A);
    rd(8'h04, 8'h01);
    rd(8'h0C, 8'h3C);
    rd(8'h04, 8'h00);
    wr(8'h08, 32'h00000040);
    set_mode1(8'h23);
    u_far.send(8'h5A, 1'b0, 1'b0, 1'b1);
    u_far.send(8'h3C, 1'b0, 1'b0, 1'b0);
    rd(8'h04, 8'h81);
    rd(8'h0C, 8'h5A);
    rd(8'h04, 8'h81);
    rd(8'h0C, 8'h3C);
    rd(8'h04, 8'h80);
    wr(8'h08, 32'h00000040);
    rd(8'h04, 8'h00);
    $display("Test error modes done");
    wr(8'h08, 32'h00000020);
    set_mode1(8'h93);
    wr(8'h28, 32'h00000001);
    wr(8'h24, 32'h00000010);
    ticks(2);
    check("rts_n", 8'h00, {7'h00, rts_n});
    check("pin_four", 8'h01, {7'h00, pin_four});
    fill0 = rnd();
    u_far.send(fill0, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 3; i++)
      u_far.send(rnd(), 1'b0, 1'b0, 1'b0);
    ticks(2);
    check("pin_four", 8'h00, {7'h00, pin_four});
    check("rts_n", 8'h00, {7'h00, rts_n});
    u_far.send(rnd(), 1'b0, 1'b0, 1'b0);
    ticks(3);
    check("rts_n", 8'h01, {7'h00, rts_n});
    set_mode1(8'hD3);
    wr(8'h1C, 32'h00000002);
    ticks(3);
    check("pin_four", 8'h00, {7'h00, pin_four});
    check("irq_n", 8'h00, {7'h00, irq_n});
    rd(8'h0C, fill0);
    ticks(3);
    check("rts_n", 8'h00, {7'h00, rts_n});
    check("pin_four", 8'h01, {7'h00, pin_four});
    check("irq_n", 8'h01, {7'h00, irq_n});
    rd(8'h28, 8'h01);
    wr(8'h28, 32'h00000000);
    ticks(3);
    check("rts_n", 8'h01, {7'h00, rts_n});
    $display("Test flow control done");
    for (int b = 0; b < 7; b++) begin
      if (b != 1) begin
        wr(8'h1C, 32'h00000001 << b);
        @(posedge pclk);
        cond <= 7'h01 << b;
        ticks(3);
        check("irq_n", 8'h00, {7'h00, irq_n});
        @(posedge pclk);
        cond <= ~(7'h01 << b) & 7'h7D;
        ticks(3);
        check("irq_n", 8'h01, {7'h00, irq_n});
      end
    end
    $display("Test interrupt mask done");
    wr(8'h10, 32'h0000000F);
    wr(8'h1C, 32'h00000080);
    @(posedge pclk);
    pins <= 4'h1;
    ticks(5);
    check("irq_n", 8'h00, {7'h00, irq_n});
    rd(8'h14, 8'h11);
    rd(8'h14, 8'h01);
    ticks(1);
    check("irq_n", 8'h01, {7'h00, irq_n});
    $display("Test input port done");
    results();
  end
endmodule
`default_nettype wire

// File: sim/uart_regs_monitor.sv
// Purpose: Port-level checks of the mode, status and interrupt block.
// Assumes: Mask writes seen on the bus mirror the internal mask.
// Notes: Attached by bind below.
`timescale 1ns/100ps
`default_nettype none
module uart_regs_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transmit_ready,
  input wire logic receiver_rts_out_n,
  input wire logic brg_set_two,
  input wire logic [7:0] counter_high,
  input wire logic irq_n
);
  logic [7:0] mask_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mask_seen <= 8'h00;
    else if (psel && penable && pready && pwrite && paddr == 8'h1C)
      mask_seen <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_done(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  sequence setup_of(logic [7:0] a);
    psel && !penable && paddr == a;
  endsequence
  answer_in_one_a: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");
  unmapped_err_a: assert property (setup_of(8'h2C) |=>
    pready && pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  rts_release_a: assert property (
    wr_done(8'h28) ##0 !pwdata[0] |-> ##2 receiver_rts_out_n)
    else $error("request to send not negated");
  brg_set_a: assert property (
    wr_done(8'h10) |-> ##2 brg_set_two == $past(pwdata[7], 2))
    else $error("rate set select wrong");
  preset_high_a: assert property (
    wr_done(8'h20) |-> ##2 counter_high == $past(pwdata[7:0], 2))
    else $error("counter preset high wrong");
  irq_raise_a: assert property (
    (transmit_ready && mask_seen[0]) [*3] |-> !irq_n)
    else $error("enabled condition gave no interrupt");
  irq_quiet_a: assert property ((mask_seen == 8'h00) [*3] |-> irq_n)
    else $error("interrupt with all conditions masked");
endmodule
bind uart_mode_one_and_interrupt_regs uart_regs_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .transmit_ready(transmit_ready),
  .receiver_rts_out_n(receiver_rts_out_n), .brg_set_two(brg_set_two),
  .counter_high(counter_high), .irq_n(irq_n));
`default_nettype wire
